// File: hdl/btc_pkg.sv
// package for the bus trigger comparator: register map, modes, fields, reset values
package btc_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int PTR_W = 3;
	localparam int CNT_W = 4;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CMPA   = 8'h04;
	localparam logic [7:0] OFS_CMPB   = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_FIFO   = 8'h10;
	localparam logic [7:0] OFS_IRQ_ST = 8'h14;
	localparam logic [7:0] OFS_IRQ_CL = 8'h18;
	localparam logic [7:0] OFS_IRQ_EN = 8'h1C;

	// control register field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_RUN_BIT  = 4;
	localparam int CTRL_EXRW_BIT = 5;
	localparam int CTRL_RWEN_BIT = 6;
	localparam int CTRL_BRK_BIT  = 7;
	localparam int CTRL_TAG_BIT  = 8;

	// interrupt status bit positions
	localparam int IRQ_TRIG_BIT = 0;
	localparam int IRQ_FULL_BIT = 1;
	localparam int IRQ_W = 2;

	// reset values
	localparam logic [ADDR_W-1:0] CMP_RESET = 16'h0000;

	typedef enum logic [3:0] {
		BTC_MODE_A_ONLY,
		BTC_MODE_A_OR_B,
		BTC_MODE_A_THEN_B,
		BTC_MODE_A_AND_DATA,
		BTC_MODE_A_NOT_DATA,
		BTC_MODE_EVT_B,
		BTC_MODE_A_THEN_EVT_B,
		BTC_MODE_INSIDE,
		BTC_MODE_OUTSIDE
	} btc_mode_e;
endpackage

// File: hdl/btc_fifo_mem.sv
// capture memory for the trigger comparator, registered read data
`timescale 1ns/100ps
`default_nettype none
module btc_fifo_mem
	import btc_pkg::*;
(
	// clock
	input  wire logic                 clk_i,
	// write port
	input  wire logic                 wr_en_i,
	input  wire logic [PTR_W-1:0]     wr_addr_i,
	input  wire logic [DATA_W-1:0]    wr_data_i,
	// read port
	input  wire logic [PTR_W-1:0]     rd_addr_i,
	output logic      [DATA_W-1:0]    rd_data_o
);
	logic [DATA_W-1:0] mem [FIFO_DEPTH];

	// storage write and registered read
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule
`default_nettype wire

// File: hdl/btc_top.sv
// bus trigger comparator: watches bus cycles, raises triggers, breakpoints and captures data
`timescale 1ns/100ps
`default_nettype none
module btc_top
	import btc_pkg::*;
(
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 reset_n_i,
	// apb slave
	input  wire logic                 psel_i,
	input  wire logic                 penable_i,
	input  wire logic                 pwrite_i,
	input  wire logic [7:0]           paddr_i,
	input  wire logic [31:0]          pwdata_i,
	output logic      [31:0]          prdata_o,
	output logic                      pready_o,
	output logic                      pslverr_o,
	// watched processor bus
	input  wire logic                 bus_valid_i,
	input  wire logic [btc_pkg::ADDR_W-1:0] bus_addr_i,
	input  wire logic [btc_pkg::DATA_W-1:0] bus_data_i,
	input  wire logic                 bus_read_i,
	// results
	output logic                      trigger_o,
	output logic                      breakpoint_o,
	output logic                      run_o,
	output logic                      irq_o
);
	import btc_pkg::*;

	typedef struct packed {
		logic [3:0]        mode;
		logic              run;
		logic              expected_read_write;
		logic              read_write_compare_enable;
		logic              breakpoint_request_enable;
		logic              tag;
		logic [ADDR_W-1:0] cmp_a;
		logic [ADDR_W-1:0] cmp_b;
		logic              armed;
		logic [PTR_W-1:0]  wr_ptr;
		logic [PTR_W-1:0]  rd_ptr;
		logic [CNT_W-1:0]  count;
		logic [IRQ_W-1:0]  irq_st;
		logic [IRQ_W-1:0]  irq_en;
		logic              trigger;
		logic              brk;
		logic [31:0]       rdata;
	} btc_state_s;

	btc_state_s state_reg;
	btc_state_s state_next;

	logic              mem_wr;
	logic [DATA_W-1:0] mem_rd_data;
	logic              acc;
	logic              wr_acc;
	logic              rd_acc;
	logic              rd_setup;
	logic              a_hit;
	logic              b_hit;
	logic              d_hit;
	logic              rw_ok;
	logic              fire;
	logic              cap;
	logic              brk_hit;
	logic              fifo_full;
	logic              fifo_pop;
	logic              mapped;

	// equality of the bus address against one comparator
	function automatic logic addr_eq(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] c);
		return a == c;
	endfunction

	// apb decode: zero-wait, answer in the access cycle
	assign acc      = psel_i & penable_i;
	assign wr_acc   = acc & pwrite_i;
	assign rd_acc   = acc & ~pwrite_i;
	assign rd_setup = psel_i & ~penable_i & ~pwrite_i; // read register loads here, stands in the access cycle
	assign pready_o = 1'b1;
	assign mapped   = (paddr_i[7:5] == 3'h0) && (paddr_i[1:0] == 2'h0);
	assign pslverr_o = acc & ~mapped;

	// comparator matches for the current bus cycle
	assign a_hit     = bus_valid_i & addr_eq(bus_addr_i, state_reg.cmp_a);
	assign b_hit     = bus_valid_i & addr_eq(bus_addr_i, state_reg.cmp_b);
	assign d_hit     = bus_data_i == state_reg.cmp_b[DATA_W-1:0];
	assign rw_ok     = ~state_reg.read_write_compare_enable | (bus_read_i == state_reg.expected_read_write);
	assign fifo_full = state_reg.count == CNT_W'(FIFO_DEPTH);
	assign fifo_pop  = rd_acc && (paddr_i == OFS_FIFO) && (state_reg.count != '0);

	// mode decode: trigger, capture and breakpoint conditions
	always_comb begin
		fire    = 1'b0;
		cap     = 1'b0;
		brk_hit = 1'b0;
		case (btc_mode_e'(state_reg.mode))
			BTC_MODE_A_ONLY: begin
				fire = a_hit;
			end
			BTC_MODE_A_OR_B: begin
				fire = a_hit | b_hit;
			end
			BTC_MODE_A_THEN_B: begin
				fire = state_reg.armed & b_hit;
			end
			BTC_MODE_A_AND_DATA: begin
				fire = a_hit & d_hit & rw_ok;
			end
			BTC_MODE_A_NOT_DATA: begin
				fire = a_hit & ~d_hit & rw_ok;
			end
			BTC_MODE_EVT_B: begin
				fire = b_hit;
				cap  = b_hit;
			end
			BTC_MODE_A_THEN_EVT_B: begin
				fire = state_reg.armed & b_hit;
				cap  = fire;
			end
			BTC_MODE_INSIDE: begin
				fire = bus_valid_i && (bus_addr_i >= state_reg.cmp_a) && (bus_addr_i <= state_reg.cmp_b);
			end
			BTC_MODE_OUTSIDE: begin
				fire = bus_valid_i && ((bus_addr_i < state_reg.cmp_a) || (bus_addr_i > state_reg.cmp_b));
			end
			default: begin
				fire = 1'b0;
			end
		endcase
		fire = fire & state_reg.run;
		cap  = cap & state_reg.run;
		// tag request in full modes ignores the data compare
		if (state_reg.tag && ((state_reg.mode == 4'(BTC_MODE_A_AND_DATA)) ||
				(state_reg.mode == 4'(BTC_MODE_A_NOT_DATA)))) begin
			brk_hit = state_reg.run & a_hit;
		end else begin
			brk_hit = fire;
		end
		brk_hit = brk_hit & state_reg.breakpoint_request_enable;
	end

	assign mem_wr = cap & ~fifo_full;

	// next-state logic: registers, sequencer, fifo pointers, interrupts
	always_comb begin
		state_next         = state_reg;
		state_next.trigger = fire;
		state_next.brk     = brk_hit;
		// arming for the sequence modes
		if (state_reg.run && a_hit && ((state_reg.mode == 4'(BTC_MODE_A_THEN_B)) ||
				(state_reg.mode == 4'(BTC_MODE_A_THEN_EVT_B)))) begin
			state_next.armed = 1'b1;
		end
		// capture and drain
		if (mem_wr) begin
			state_next.wr_ptr = state_reg.wr_ptr + PTR_W'(1);
		end
		if (fifo_pop) begin
			state_next.rd_ptr = state_reg.rd_ptr + PTR_W'(1);
		end
		state_next.count = state_reg.count + CNT_W'(mem_wr) - CNT_W'(fifo_pop);
		// end the run once the capture store is full
		if (cap && (state_next.count == CNT_W'(FIFO_DEPTH))) begin
			state_next.run = 1'b0;
		end
		// software writes
		if (wr_acc) begin
			case (paddr_i)
				OFS_CTRL: begin
					state_next.mode = pwdata_i[CTRL_MODE_LSB +: 4];
					state_next.run  = pwdata_i[CTRL_RUN_BIT];
					state_next.expected_read_write       = pwdata_i[CTRL_EXRW_BIT];
					state_next.read_write_compare_enable = pwdata_i[CTRL_RWEN_BIT];
					state_next.breakpoint_request_enable = pwdata_i[CTRL_BRK_BIT];
					state_next.tag   = pwdata_i[CTRL_TAG_BIT];
					state_next.armed = 1'b0;
					if (pwdata_i[CTRL_RUN_BIT] && !state_reg.run) begin
						state_next.wr_ptr = '0;
						state_next.rd_ptr = '0;
						state_next.count  = '0;
					end
				end
				OFS_CMPA: begin
					state_next.cmp_a = pwdata_i[ADDR_W-1:0];
				end
				OFS_CMPB: begin
					state_next.cmp_b = pwdata_i[ADDR_W-1:0];
				end
				OFS_IRQ_CL: begin
					state_next.irq_st = state_reg.irq_st & ~pwdata_i[IRQ_W-1:0];
				end
				OFS_IRQ_EN: begin
					state_next.irq_en = pwdata_i[IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// events set sticky bits; set wins over clear
		if (fire) begin
			state_next.irq_st[IRQ_TRIG_BIT] = 1'b1;
		end
		if (mem_wr && (state_next.count == CNT_W'(FIFO_DEPTH))) begin
			state_next.irq_st[IRQ_FULL_BIT] = 1'b1;
		end
		// read data mux, loaded at the setup edge so the word stands through the access cycle
		state_next.rdata = 32'h0000_0000;
		if (rd_setup) begin
			case (paddr_i)
				OFS_CTRL: begin
					state_next.rdata = {23'h0, state_reg.tag, state_reg.breakpoint_request_enable,
						state_reg.read_write_compare_enable, state_reg.expected_read_write,
						state_reg.run, state_reg.mode};
				end
				OFS_CMPA: begin
					state_next.rdata = {16'h0000, state_reg.cmp_a};
				end
				OFS_CMPB: begin
					state_next.rdata = {16'h0000, state_reg.cmp_b};
				end
				OFS_STATUS: begin
					state_next.rdata = {26'h0, fifo_full, state_reg.armed, state_reg.count};
				end
				OFS_IRQ_ST: begin
					state_next.rdata = {30'h0, state_reg.irq_st};
				end
				OFS_IRQ_EN: begin
					state_next.rdata = {30'h0, state_reg.irq_en};
				end
				default: begin
					state_next.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg       <= '0;
			state_reg.cmp_a <= CMP_RESET;
			state_reg.cmp_b <= CMP_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// capture storage
	btc_fifo_mem u_mem (
		.clk_i     (clk_i),
		.wr_en_i   (mem_wr),
		.wr_addr_i (state_reg.wr_ptr),
		.wr_data_i (bus_data_i),
		.rd_addr_i (state_reg.rd_ptr),
		.rd_data_o (mem_rd_data)
	);

	// outputs: fifo reads present the head word, registers otherwise
	assign prdata_o     = (rd_acc && paddr_i == OFS_FIFO) ? {24'h000000, mem_rd_data} : state_reg.rdata;
	assign trigger_o    = state_reg.trigger;
	assign breakpoint_o = state_reg.brk;
	assign run_o        = state_reg.run;
	assign irq_o        = |(state_reg.irq_st & state_reg.irq_en);
endmodule
`default_nettype wire

// File: bench/btc_top_assertions.sv
// checker for the bus trigger comparator ports
`timescale 1ns/100ps
`default_nettype none
module btc_top_assertions (
	// clock and reset
	input wire logic                       clk_i,
	input wire logic                       reset_n_i,
	// apb slave
	input wire logic                       psel_i,
	input wire logic                       penable_i,
	input wire logic                       pwrite_i,
	input wire logic [7:0]                 paddr_i,
	input wire logic [31:0]                pwdata_i,
	input wire logic [31:0]                prdata_o,
	input wire logic                       pready_o,
	input wire logic                       pslverr_o,
	// watched processor bus
	input wire logic                       bus_valid_i,
	input wire logic [btc_pkg::ADDR_W-1:0] bus_addr_i,
	input wire logic [btc_pkg::DATA_W-1:0] bus_data_i,
	input wire logic                       bus_read_i,
	// results
	input wire logic                       trigger_o,
	input wire logic                       breakpoint_o,
	input wire logic                       run_o,
	input wire logic                       irq_o
);
	import btc_pkg::*;
	logic [8:0] ct;
	logic [15:0] ca, cb;
	wire ok = run_o && bus_valid_i;
	wire ea = bus_addr_i == ca;
	wire eb = bus_addr_i == cb;
	wire dm = bus_data_i == cb[7:0];
	wire rw = !ct[6] || (bus_read_i == ct[5]);
	// shadow of the configuration written over apb
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ct <= '0;
			ca <= '0;
			cb <= '0;
		end else if (psel_i && penable_i && pwrite_i) begin
			if (paddr_i == OFS_CTRL) ct <= pwdata_i[8:0];
			if (paddr_i == OFS_CMPA) ca <= pwdata_i[15:0];
			if (paddr_i == OFS_CMPB) cb <= pwdata_i[15:0];
		end
	end
	default clocking cb_clk @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	property p_a_hit; ok && ct[3:0] == 4'h0 && ea |=> trigger_o; endproperty
	property p_a_miss; ok && ct[3:0] == 4'h0 && !ea |=> !trigger_o; endproperty
	property p_a_or_b; ok && ct[3:0] == 4'h1 && (ea || eb) |=> trigger_o; endproperty
	property p_full; ok && ct[3:0] == 4'h3 && !ct[8] && ea && dm && rw |=> trigger_o; endproperty
	property p_not_data; ok && ct[3:0] == 4'h4 && ea && dm |=> !trigger_o; endproperty
	property p_evt_b; ok && ct[3:0] == 4'h5 && eb |=> trigger_o; endproperty
	property p_inside; ok && ct[3:0] == 4'h7 && bus_addr_i >= ca && bus_addr_i <= cb |=> trigger_o; endproperty
	property p_outside; ok && ct[3:0] == 4'h8 && (bus_addr_i < ca || bus_addr_i > cb) |=> trigger_o; endproperty
	property p_unmapped; psel_i && penable_i && paddr_i >= 8'h20 |-> pslverr_o && pready_o; endproperty
	property p_tag_brk; ok && ct[3:0] == 4'h3 && ct[8] && ct[7] && ea |=> breakpoint_o; endproperty
	property p_brk_off; !ct[7] |=> !breakpoint_o; endproperty
	a_a_hit: assert property (p_a_hit) else $error("no trigger on A match");
	a_a_miss: assert property (p_a_miss) else $error("trigger without A match");
	a_a_or_b: assert property (p_a_or_b) else $error("no trigger on A or B");
	a_full: assert property (p_full) else $error("no full match trigger");
	a_not_data: assert property (p_not_data) else $error("trigger on data match");
	a_evt_b: assert property (p_evt_b) else $error("no event on B match");
	a_inside: assert property (p_inside) else $error("no inside trigger");
	a_outside: assert property (p_outside) else $error("no outside trigger");
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	a_tag_brk: assert property (p_tag_brk) else $error("no tag breakpoint on A match");
	a_brk_off: assert property (p_brk_off) else $error("breakpoint while requests disabled");
	c_run_end: cover property (run_o ##1 !run_o);
	c_brk: cover property (breakpoint_o);
	c_irq: cover property (irq_o);
endmodule
bind btc_top btc_top_assertions chk_u (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
	.prdata_o, .pready_o, .pslverr_o, .bus_valid_i, .bus_read_i, .bus_addr_i, .bus_data_i, .trigger_o,
	.breakpoint_o, .run_o, .irq_o);
`default_nettype wire

// File: bench/btc_cpu_model.sv
// processor bus model: issues one bus cycle at a time
`timescale 1ns/100ps
`default_nettype none
module btc_cpu_model (
	input wire logic clk_i,
	output logic bus_valid_o = 1'b0,
	output logic [15:0] bus_addr_o = 16'h0000,
	output logic [7:0] bus_data_o = 8'h00,
	output logic bus_read_o = 1'b0
);
	// one valid cycle, then idle lines flip so stale values never match
	task cyc(input logic [15:0] a, input logic [7:0] d, input logic r);
		@(posedge clk_i);
		bus_valid_o <= 1'b1;
		bus_addr_o <= a;
		bus_data_o <= d;
		bus_read_o <= r;
		@(posedge clk_i);
		bus_valid_o <= 1'b0;
		bus_addr_o <= ~a;
		bus_data_o <= ~d;
		bus_read_o <= ~r;
	endtask
endmodule
`default_nettype wire

// File: bench/tb_bus_trigger_comparator.sv
// testbench for the bus trigger comparator
`timescale 1ns/100ps
`default_nettype none
module tb_bus_trigger_comparator;
	import btc_pkg::*;
	logic clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, sl;
	logic [7:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o, rd;
	logic pready_o, pslverr_o, bus_valid_i, bus_read_i, trigger_o, breakpoint_o, run_o, irq_o;
	logic [ADDR_W-1:0] bus_addr_i, ra[5];
	logic [DATA_W-1:0] bus_data_i;
	int fails = 0, total_checks = 0;
	btc_top dut_u (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .bus_valid_i, .bus_addr_i, .bus_data_i, .bus_read_i, .trigger_o,
		.breakpoint_o, .run_o, .irq_o);
	btc_cpu_model cpu_u (.clk_i, .bus_valid_o(bus_valid_i), .bus_addr_o(bus_addr_i),
		.bus_data_o(bus_data_i), .bus_read_o(bus_read_i));
	// clock
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one apb transfer, data and error taken at the ready edge
	task apb(input int w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1;
		pwrite_i <= (w != 0);
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		sl = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
		#1;
	endtask
	task cfg(input logic [15:0] a, input logic [15:0] b, input logic [8:0] c);
		apb(1, OFS_CMPA, {16'h0000, a});
		apb(1, OFS_CMPB, {16'h0000, b});
		apb(1, OFS_CTRL, {23'h0, c} | 32'h10);
	endtask
	// bus cycle, then the trigger pulse one cycle later
	task bc(input logic [15:0] a, input int d, input int r, input int t);
		cpu_u.cyc(a, 8'(d), r != 0);
		#1;
		chk({31'h0, trigger_o}, 32'(t));
	endtask
	// watchdog: about twenty times the length of the tests
	initial begin
		#20000;
		fails++;
		close_out();
	end
	initial begin
		ra = '{16'h00FF, 16'h0100, 16'h0180, 16'h0200, 16'h0201};
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1;
		cfg(16'h1234, 16'h0000, 9'h000);
		bc(16'h1234, 8'h00, 1, 1);
		chk({31'h0, breakpoint_o}, 32'h0);
		apb(0, OFS_CTRL, 0);
		chk(rd, 32'h0000_0010);
		chk({31'h0, sl}, 32'h0);
		apb(0, OFS_CMPA, 0);
		chk(rd, 32'h0000_1234);
		bc(16'h1235, 8'h00, 1, 0);
		cfg(16'h1000, 16'h2000, 9'h001);
		bc(16'h2000, 8'h00, 0, 1);
		bc(16'h1000, 8'h00, 0, 1);
		bc(16'h3000, 8'h00, 0, 0);
		cfg(16'h0A00, 16'h0B00, 9'h002);
		bc(16'h0B00, 8'h00, 0, 0);
		bc(16'h0A00, 8'h00, 0, 0);
		bc(16'h0C00, 8'h00, 0, 0);
		bc(16'h0B00, 8'h00, 0, 1);
		cfg(16'h0300, 16'hAB55, 9'h063);
		bc(16'h0300, 8'h55, 1, 1);
		bc(16'h0300, 8'h55, 0, 0);
		bc(16'h0300, 8'hAB, 1, 0);
		bc(16'h0301, 8'h55, 1, 0);
		cfg(16'h0300, 16'hAB55, 9'h064);
		bc(16'h0300, 8'h56, 1, 1);
		bc(16'h0300, 8'h55, 1, 0);
		cfg(16'h0300, 16'hAB55, 9'h183);
		bc(16'h0300, 8'h99, 0, 0);
		chk({31'h0, breakpoint_o}, 32'h1);
		apb(1, OFS_IRQ_EN, 32'h2);
		cfg(16'h0000, 16'h4000, 9'h005);
		for (int i = 0; i < 8; i++) bc(16'h4000, 8'hA0 + i, 0, 1);
		chk({31'h0, run_o}, 32'h0);
		chk({31'h0, irq_o}, 32'h1);
		apb(0, OFS_STATUS, 0);
		chk(rd, 32'h0000_0028);
		apb(0, OFS_IRQ_ST, 0);
		chk(rd, 32'h0000_0003);
		for (int i = 0; i < 8; i++) begin
			apb(0, OFS_FIFO, 0);
			chk(rd, 32'hA0 + i);
		end
		apb(1, OFS_IRQ_CL, 32'h3);
		chk({31'h0, irq_o}, 32'h0);
		apb(0, 8'h20, 0);
		chk({31'h0, sl}, 32'h1);
		apb(1, 8'h06, 32'hFFFF_FFFF);
		chk({31'h0, sl}, 32'h1);
		cfg(16'h5000, 16'h5100, 9'h006);
		bc(16'h5100, 8'h11, 0, 0);
		bc(16'h5000, 8'h00, 0, 0);
		bc(16'h5100, 8'h22, 0, 1);
		apb(0, OFS_FIFO, 0);
		chk(rd, 32'h22);
		for (int m = 7; m < 9; m++) begin
			cfg(16'h0100, 16'h0200, m[8:0]);
			for (int i = 0; i < 5; i++)
				bc(ra[i], 8'h00, 0, (m == 7) ? (ra[i] >= 16'h0100 && ra[i] <= 16'h0200)
					: (ra[i] < 16'h0100 || ra[i] > 16'h0200));
		end
		// reset in mid-run brings the configuration back to its reset values
		@(posedge clk_i);
		reset_n_i <= 0;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1;
		#1;
		chk({31'h0, run_o}, 32'h0);
		apb(0, OFS_CMPA, 0);
		chk(rd, {16'h0000, CMP_RESET});
		close_out();
	end
endmodule
`default_nettype wire
